// File: rtl/lpt_pkg.sv
// shared constants and types of the logger power and trigger control
package lpt_pkg;
    // time base
    localparam int CLK_MHZ = 40;
    localparam int TICK_US = 1000;
    localparam int TICK_CYC = TICK_US * CLK_MHZ;
    localparam int MS_PER_S = 1000;
    localparam int CONT_REMOTE_S = 1;
    localparam int CONT_REMOTE_MS = CONT_REMOTE_S * MS_PER_S;
    localparam int EMERG_H = 2;
    localparam int EMERG_S = EMERG_H * 3600;
    localparam int DEB_MS = 20;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_FOLLOW = 8'h04;
    localparam logic [7:0] ADDR_POSTLIM = 8'h08;
    localparam logic [7:0] ADDR_WAKETO = 8'h0c;
    localparam logic [7:0] ADDR_CAL_FIRST = 8'h10;
    localparam logic [7:0] ADDR_CAL_PERIOD = 8'h14;
    localparam logic [7:0] ADDR_TRIG_MODE = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1c;
    // control field positions
    localparam int CTRL_IGN_EN = 0;
    localparam int CTRL_BUS_EN = 1;
    localparam int CTRL_CAL_EN = 2;
    localparam int CTRL_TEXT_EN = 3;
    localparam int CTRL_CAL_MODE = 4;
    localparam int CTRL_ROLL = 6;
    localparam int CTRL_SW_OFF = 7;
    localparam int CTRL_POST_DONE = 8;
    localparam int CTRL_W = 6;
    // status field positions
    localparam int STAT_STATE = 0;
    localparam int STAT_IGN = 3;
    localparam int STAT_BUS = 4;
    localparam int STAT_TEXT = 5;
    localparam int STAT_CAL_PEND = 6;
    localparam int STAT_EMERG = 7;
    localparam int STAT_CONT = 8;
    localparam int STAT_STORE = 16;
    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 6'h01;
    localparam logic [15:0] FOLLOW_RST = 16'h003c;
    localparam logic [15:0] POSTLIM_RST = 16'h0168;
    localparam logic [15:0] WAKETO_RST = 16'h003c;
    localparam logic [31:0] CAL_FIRST_RST = 32'h0000_0e10;
    localparam logic [31:0] CAL_PERIOD_RST = 32'h0001_5180;

    typedef enum logic [2:0] {
        ST_STANDBY = 3'b000,
        ST_ACQ = 3'b001,
        ST_ROLL = 3'b010,
        ST_FOLLOW = 3'b011,
        ST_POST = 3'b100
    } lpt_pwr_t;

    typedef enum logic [1:0] {
        TM_START = 2'b00,
        TM_STOP = 2'b01,
        TM_START_STOP = 2'b10,
        TM_INVERT = 2'b11
    } lpt_tmode_t;

    typedef enum logic [1:0] {
        CAL_OFF = 2'b00,
        CAL_ONCE = 2'b01,
        CAL_CYCLIC = 2'b10,
        CAL_DURATION = 2'b11
    } lpt_cal_t;
endpackage

// File: rtl/lpt_grp_if.sv
// signals between the controller and one storage group
`timescale 1ns/1ps
interface lpt_grp_if;
    lpt_pkg::lpt_tmode_t mode;
    logic run;
    logic power_up;
    logic start;
    logic stop;
    logic level;
    logic store;
    modport ctl (output mode, run, power_up, start, stop, level, input store);
    modport grp (input mode, run, power_up, start, stop, level, output store);
endinterface

// File: rtl/lpt_debounce.sv
// input synchroniser with tick-based debounce and edge pulses
`timescale 1ns/1ps
module lpt_debounce #(
    parameter int CNT_W = 8,
    parameter int DEB_TICKS = 20
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic raw,
    output logic level,
    output logic rise,
    output logic fall
);
    logic sync_a;
    logic sync_b;
    logic [CNT_W-1:0] cnt;

    if (DEB_TICKS < 1 || DEB_TICKS >= (1 << CNT_W)) begin : g_chk
        $error("debounce count does not fit counter");
    end

    // two-flop synchroniser
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= raw;
            sync_b <= sync_a;
        end
    end

    // level follows only after a stable run of ticks
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
            level <= 1'b0;
            rise <= 1'b0;
            fall <= 1'b0;
        end else begin
            rise <= 1'b0;
            fall <= 1'b0;
            if (sync_b == level) begin
                cnt <= '0;
            end else if (tick) begin
                if (cnt == CNT_W'(DEB_TICKS - 1)) begin
                    cnt <= '0;
                    level <= sync_b;
                    rise <= sync_b;
                    fall <= ~sync_b;
                end else begin
                    cnt <= cnt + 1'b1;
                end
            end
        end
    end
endmodule

// File: rtl/lpt_trig_group.sv
// storage gate of one storage group, four trigger modes
`timescale 1ns/1ps
module lpt_trig_group (
    input wire logic clk,
    input wire logic rst_n,
    lpt_grp_if.grp g
);
    import lpt_pkg::*;
    logic store_r;

    assign g.store = store_r;

    // storage window per mode, closed in any cycle with neither run nor power_up
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            store_r <= 1'b0;
        end else if (!g.run && !g.power_up) begin
            store_r <= 1'b0; // R12 R14 R15 R16
        end else begin
            unique case (g.mode)
                TM_START: begin
                    if (g.start) begin
                        store_r <= 1'b1; // R12
                    end
                end
                TM_STOP: begin
                    if (g.power_up) begin
                        store_r <= 1'b1; // R14
                    end else if (g.stop) begin
                        store_r <= 1'b0; // R14
                    end
                end
                TM_START_STOP: begin
                    if (g.start) begin
                        store_r <= 1'b1; // R15
                    end else if (g.stop) begin
                        store_r <= 1'b0; // R15
                    end
                end
                TM_INVERT: begin
                    store_r <= g.level; // R16
                end
            endcase
        end
    end
endmodule

// File: rtl/lpt_ctrl.sv
// logger power sequencing, wake sources and storage-group triggering
// Operation
// R1: ignition high over 1 s restarts acquisition
// R2: forced power-off 2 h after ignition fall
// R3: bus wake with ignition needs remote before timeout
// R4: bus-only wake: switch-off condition only
// R5: calendar single-shot wake
// R6: calendar cyclic wake from programmed first moment
// R7: calendar interval wake without start moment
// R8: network indicators green while wake sources configured; code: not for ignition enable alone, also lit outside standby
// R9: rollover closes file and opens new one
// R10: four trigger modes per storage group
// R11: buffered data flushed while storage holds
// R12: start mode: trigger to power-down
// R13: follow-up time extends acquisition
// R14: stop mode: power-up to trigger
// R15: start-stop mode: start to stop trigger
// R16: inverted mode: store while level true
// R17: post-processing limit forces power-down
// R18: configurer keeps limit 5 min above follow-up
// R19: wake timeout bounds wait for remote
// R20: follow-up period before shutdown begins
// R21: ignition line debounced before use
// R22: after shutdown watch enabled wake sources
`timescale 1ns/1ps
module lpt_ctrl #(
    parameter int GROUPS = 4,
    parameter int MS_CYC = lpt_pkg::TICK_CYC,
    parameter int EMERG_SEC = lpt_pkg::EMERG_S,
    parameter int DEB_TICKS = lpt_pkg::DEB_MS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ignition_remote_line,
    input wire logic bus_activity_pin,
    input wire logic text_message_pin,
    input wire logic [GROUPS-1:0] trig_start,
    input wire logic [GROUPS-1:0] trig_stop,
    input wire logic [GROUPS-1:0] trig_level,
    input wire logic [GROUPS-1:0] buf_pending,
    output logic power_hold,
    output logic acq_run,
    output logic file_open,
    output logic file_close,
    output logic [GROUPS-1:0] flush_req,
    output logic led_green
);
    import lpt_pkg::*;

    if (GROUPS < 1 || GROUPS > 8) begin : g_chk_grp
        $error("GROUPS must be 1 to 8");
    end
    if (MS_CYC < 2 || MS_CYC > 65536) begin : g_chk_ms
        $error("MS_CYC must be 2 to 65536");
    end
    if (EMERG_SEC < 1 || EMERG_SEC > 65535) begin : g_chk_em
        $error("EMERG_SEC must be 1 to 65535");
    end

    logic [CTRL_W-1:0] ctrl;
    logic [15:0] follow_s;
    logic [15:0] postlim_s;
    logic [15:0] waketo_s;
    logic [31:0] cal_first;
    logic [31:0] cal_period;
    logic [2*GROUPS-1:0] trig_mode;
    logic [15:0] ms_div;
    logic [9:0] ms_in_s;
    logic ms_tick;
    logic sec_tick;
    logic ign_lvl;
    logic ign_rise;
    logic ign_fall;
    logic bus_lvl;
    logic text_lvl;
    logic [10:0] remote_ms;
    logic cont_remote;
    logic [15:0] emerg_cnt;
    logic emerg_armed;
    logic emerg_fire;
    logic [31:0] cal_cnt;
    logic cal_armed;
    logic cal_fire;
    logic cal_pend;
    logic cal_load;
    logic [15:0] st_sec;
    logic [15:0] post_sec;
    logic woke_other;
    lpt_pwr_t state;
    lpt_pwr_t next_state;
    logic wr_en;
    logic rd_setup;
    logic [31:0] rd_val;
    logic rd_hit;
    logic roll_req;
    logic sw_off_req;
    logic post_done;
    logic cfg_load;
    logic bus_only;
    logic wake_req;
    logic open_p;
    logic close_p;
    logic run;
    logic power_up;
    logic [GROUPS-1:0] store;
    lpt_cal_t cal_mode;

    assign cal_mode = lpt_cal_t'(ctrl[CTRL_CAL_MODE +: 2]);
    assign bus_only = ctrl[CTRL_BUS_EN] & ~ctrl[CTRL_IGN_EN];
    assign wr_en = psel & penable & pready & pwrite;
    assign rd_setup = psel & ~penable;
    assign roll_req = wr_en && paddr == ADDR_CTRL && pwdata[CTRL_ROLL];
    assign sw_off_req = wr_en && paddr == ADDR_CTRL && pwdata[CTRL_SW_OFF];
    assign post_done = wr_en && paddr == ADDR_CTRL && pwdata[CTRL_POST_DONE];
    assign cfg_load = wr_en && (paddr == ADDR_CTRL || paddr == ADDR_CAL_FIRST
                      || paddr == ADDR_CAL_PERIOD);

    // millisecond and second enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_div <= '0;
            ms_in_s <= '0;
            ms_tick <= 1'b0;
            sec_tick <= 1'b0;
        end else begin
            ms_tick <= 1'b0;
            sec_tick <= 1'b0;
            if (ms_div == 16'(MS_CYC - 1)) begin
                ms_div <= '0;
                ms_tick <= 1'b1;
                if (ms_in_s == 10'(MS_PER_S - 1)) begin
                    ms_in_s <= '0;
                    sec_tick <= 1'b1;
                end else begin
                    ms_in_s <= ms_in_s + 1'b1;
                end
            end else begin
                ms_div <= ms_div + 1'b1;
            end
        end
    end

    // ignition line: synchronised and debounced
    lpt_debounce #(.CNT_W(8), .DEB_TICKS(DEB_TICKS)) u_ign (
        .clk(pclk), .rst_n(presetn), .tick(ms_tick), .raw(ignition_remote_line),
        .level(ign_lvl), .rise(ign_rise), .fall(ign_fall)
    ); // R21

    // bus activity and text message wake pins
    lpt_debounce #(.CNT_W(2), .DEB_TICKS(1)) u_bus (
        .clk(pclk), .rst_n(presetn), .tick(1'b1), .raw(bus_activity_pin),
        .level(bus_lvl), .rise(), .fall()
    );
    lpt_debounce #(.CNT_W(2), .DEB_TICKS(1)) u_text (
        .clk(pclk), .rst_n(presetn), .tick(1'b1), .raw(text_message_pin),
        .level(text_lvl), .rise(), .fall()
    );

    // continuous remote: ignition high longer than one second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remote_ms <= '0;
        end else if (!ign_lvl) begin
            remote_ms <= '0;
        end else if (ms_tick && !cont_remote) begin
            remote_ms <= remote_ms + 1'b1;
        end
    end
    assign cont_remote = remote_ms > 11'(CONT_REMOTE_MS); // R1

    // hardware emergency switch-off timer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            emerg_cnt <= '0;
            emerg_armed <= 1'b0;
        end else if (ign_fall && !bus_only) begin
            emerg_cnt <= '0;
            emerg_armed <= 1'b1; // R2
        end else if (ign_rise || emerg_fire || bus_only) begin
            emerg_armed <= 1'b0; // R4
        end else if (sec_tick && emerg_armed) begin
            emerg_cnt <= emerg_cnt + 1'b1;
        end
    end
    assign emerg_fire = emerg_armed && emerg_cnt >= 16'(EMERG_SEC); // R2

    // calendar clock countdown
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_cnt <= '0;
            cal_armed <= 1'b0;
            cal_fire <= 1'b0;
            cal_load <= 1'b0;
        end else begin
            cal_fire <= 1'b0;
            cal_load <= cfg_load; // re-arm once the written word is held
            if (cal_load) begin
                cal_armed <= ctrl[CTRL_CAL_EN] && cal_mode != CAL_OFF;
                cal_cnt <= (cal_mode == CAL_DURATION) ? cal_period : cal_first; // R6 R7
            end else if (sec_tick && cal_armed) begin
                if (cal_cnt <= 32'h0000_0001) begin
                    cal_fire <= 1'b1;
                    cal_cnt <= cal_period; // R6 R7
                    cal_armed <= cal_mode != CAL_ONCE; // R5
                end else begin
                    cal_cnt <= cal_cnt - 1'b1;
                end
            end
        end
    end

    // pending calendar wake; a new event wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_pend <= 1'b0;
        end else if (cal_fire) begin
            cal_pend <= 1'b1;
        end else if (state == ST_STANDBY && next_state == ST_ACQ) begin
            cal_pend <= 1'b0;
        end
    end

    // wake request from the enabled sources
    assign wake_req = (ctrl[CTRL_IGN_EN] & ign_lvl) | (ctrl[CTRL_BUS_EN] & bus_lvl)
                      | cal_pend | (ctrl[CTRL_TEXT_EN] & text_lvl); // R22

    // power sequence next state
    always_comb begin
        next_state = state;
        unique case (state)
            ST_STANDBY: begin
                if (wake_req) begin
                    next_state = ST_ACQ; // R22
                end
            end
            ST_ACQ: begin
                if (emerg_fire) begin
                    next_state = ST_STANDBY; // R2
                end else if (roll_req) begin
                    next_state = ST_ROLL; // R9
                end else if (!bus_only && woke_other && ctrl[CTRL_IGN_EN]
                             && st_sec >= waketo_s) begin
                    next_state = ST_STANDBY; // R3 R19
                end else if (sw_off_req) begin
                    next_state = bus_only ? ST_POST : ST_FOLLOW; // R4 R20
                end else if (!bus_only && !woke_other && !ign_lvl) begin
                    next_state = ST_FOLLOW; // R20
                end
            end
            ST_ROLL: begin
                next_state = ST_ACQ; // R9
            end
            ST_FOLLOW: begin
                if (emerg_fire || post_sec >= postlim_s) begin
                    next_state = ST_STANDBY; // R2 R17
                end else if (cont_remote) begin
                    next_state = ST_ACQ;
                end else if (st_sec >= follow_s) begin
                    next_state = ST_POST; // R13 R20
                end
            end
            ST_POST: begin
                if (emerg_fire || post_done || post_sec >= postlim_s) begin
                    next_state = ST_STANDBY; // R2 R17
                end else if (cont_remote && ctrl[CTRL_IGN_EN]) begin
                    next_state = ST_ACQ; // R1
                end
            end
            default: begin
                next_state = ST_STANDBY;
            end
        endcase
    end

    assign run = state == ST_ACQ || state == ST_ROLL || state == ST_FOLLOW; // R13
    assign open_p = next_state == ST_ACQ && state != ST_ACQ && state != ST_FOLLOW;
    assign close_p = (state == ST_ACQ || state == ST_FOLLOW)
                     && next_state != ST_ACQ && next_state != ST_FOLLOW;
    assign power_up = open_p && state != ST_ROLL;

    // state register and source of the wake
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_STANDBY;
            woke_other <= 1'b0;
        end else begin
            state <= next_state;
            if (state == ST_STANDBY && next_state == ST_ACQ) begin
                woke_other <= ~(ctrl[CTRL_IGN_EN] & ign_lvl); // R3
            end else if (cont_remote) begin
                woke_other <= 1'b0; // R3
            end
        end
    end

    // seconds in state and since the switch-off signal
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_sec <= '0;
            post_sec <= '0;
        end else begin
            if (next_state != state) begin
                st_sec <= '0;
            end else if (sec_tick && st_sec != 16'hffff) begin
                st_sec <= st_sec + 1'b1;
            end
            if (state == ST_ACQ && next_state != ST_ACQ) begin
                post_sec <= '0;
            end else if (sec_tick && (state == ST_FOLLOW || state == ST_POST)
                         && post_sec != 16'hffff) begin
                post_sec <= post_sec + 1'b1; // R17
            end
        end
    end

    // one trigger gate per storage group
    for (genvar i = 0; i < GROUPS; i++) begin : g_grp
        lpt_grp_if gi ();
        assign gi.mode = lpt_tmode_t'(trig_mode[2*i +: 2]); // R10
        assign gi.run = run;
        assign gi.power_up = power_up;
        assign gi.start = trig_start[i];
        assign gi.stop = trig_stop[i];
        assign gi.level = trig_level[i];
        assign store[i] = gi.store;
        lpt_trig_group u_grp (.clk(pclk), .rst_n(presetn), .g(gi.ctl));
    end

    // registered outputs toward power supply, file system and indicators
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_hold <= 1'b0;
            acq_run <= 1'b0;
            file_open <= 1'b0;
            file_close <= 1'b0;
            flush_req <= '0;
            led_green <= 1'b0;
        end else begin
            power_hold <= next_state != ST_STANDBY;
            acq_run <= next_state == ST_ACQ || next_state == ST_ROLL || next_state == ST_FOLLOW;
            file_open <= open_p; // R9
            file_close <= close_p; // R9
            flush_req <= store & buf_pending; // R11
            led_green <= ctrl[CTRL_BUS_EN] | ctrl[CTRL_CAL_EN] | ctrl[CTRL_TEXT_EN]
                         | (state != ST_STANDBY); // R8
        end
    end

    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RST;
            follow_s <= FOLLOW_RST;
            postlim_s <= POSTLIM_RST;
            waketo_s <= WAKETO_RST;
            cal_first <= CAL_FIRST_RST;
            cal_period <= CAL_PERIOD_RST;
            trig_mode <= '0;
        end else if (wr_en) begin
            unique case (paddr)
                ADDR_CTRL: ctrl <= pwdata[CTRL_W-1:0];
                ADDR_FOLLOW: follow_s <= pwdata[15:0];
                ADDR_POSTLIM: postlim_s <= pwdata[15:0]; // R18
                ADDR_WAKETO: waketo_s <= pwdata[15:0];
                ADDR_CAL_FIRST: cal_first <= pwdata;
                ADDR_CAL_PERIOD: cal_period <= pwdata;
                ADDR_TRIG_MODE: trig_mode <= pwdata[2*GROUPS-1:0];
                default: ;
            endcase
        end
    end

    // read value decode
    always_comb begin
        rd_val = '0;
        rd_hit = 1'b1;
        unique case (paddr)
            ADDR_CTRL: rd_val[CTRL_W-1:0] = ctrl;
            ADDR_FOLLOW: rd_val[15:0] = follow_s;
            ADDR_POSTLIM: rd_val[15:0] = postlim_s;
            ADDR_WAKETO: rd_val[15:0] = waketo_s;
            ADDR_CAL_FIRST: rd_val = cal_first;
            ADDR_CAL_PERIOD: rd_val = cal_period;
            ADDR_TRIG_MODE: rd_val[2*GROUPS-1:0] = trig_mode;
            ADDR_STATUS: begin
                rd_val[STAT_STATE +: 3] = state;
                rd_val[STAT_IGN] = ign_lvl;
                rd_val[STAT_BUS] = bus_lvl;
                rd_val[STAT_TEXT] = text_lvl;
                rd_val[STAT_CAL_PEND] = cal_pend;
                rd_val[STAT_EMERG] = emerg_armed;
                rd_val[STAT_CONT] = cont_remote;
                rd_val[STAT_STORE +: GROUPS] = store;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // apb answer: ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            pready <= rd_setup;
            if (rd_setup) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_val;
                pslverr <= ~rd_hit;
            end else if (pready) begin
                pslverr <= 1'b0;
            end
        end
    end
endmodule

// File: tb/lpt_ctrl_props.sv
// port checker of the logger power and trigger control
`timescale 1ns/1ps
module lpt_ctrl_props #(
    parameter int GROUPS = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    input wire logic power_hold,
    input wire logic acq_run,
    input wire logic file_open,
    input wire logic file_close,
    input wire logic [GROUPS-1:0] buf_pending,
    input wire logic [GROUPS-1:0] flush_req
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // bus answer timing and refusal
    property p_ans; psel && !penable |=> pready; endproperty
    a_ans: assert property (p_ans) else $error("no answer after setup");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("pready held too long");
    property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
    a_err: assert property (p_err) else $error("bad refused answer");
    // file events
    property p_roll; file_open && $past(acq_run) |-> $past(file_close); endproperty
    a_roll: assert property (p_roll) else $error("reopen without close");
    property p_open; file_open |=> !file_open; endproperty
    a_open: assert property (p_open) else $error("open pulse too long");
    property p_close; file_close |=> !file_close; endproperty
    a_close: assert property (p_close) else $error("close pulse too long");
    // storage and standby
    property p_flush; (flush_req & ~$past(buf_pending)) == '0; endproperty
    a_flush: assert property (p_flush) else $error("flush without data");
    property p_stdby; !power_hold |-> !acq_run; endproperty
    a_stdby: assert property (p_stdby) else $error("run in standby");
endmodule
bind lpt_ctrl lpt_ctrl_props #(.GROUPS(GROUPS)) u_lpt_ctrl_props (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .power_hold(power_hold), .acq_run(acq_run), .file_open(file_open),
    .file_close(file_close), .buf_pending(buf_pending), .flush_req(flush_req));

// File: tb/lpt_vehicle.sv
// vehicle side model: ignition line and bus traffic pins
`timescale 1ns/1ps
module lpt_vehicle (
    input wire logic pclk,
    input wire logic ign_cmd,
    input wire logic bus_cmd,
    output logic ign = 1'b0,
    output logic bus = 1'b0
);
    // harness levels move just after the clock edge
    always @(posedge pclk) begin
        ign <= ign_cmd;
        bus <= bus_cmd;
    end
endmodule

// File: tb/lpt_ctrl_tb.sv
// self-checking bench of the logger power and trigger control
`timescale 1ns/1ps
module lpt_ctrl_tb;
    import lpt_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, ign, bus, ign_cmd = 0, bus_cmd = 0;
    logic power_hold, acq_run, file_open, file_close, led_green;
    logic [3:0] trig_start = 0, trig_stop = 0, trig_level = 0, buf_pending = 0, flush_req;
    int fail_count = 0, n_checks = 0;
    // 40 MHz clock
    always #12.5 pclk = ~pclk;
    lpt_ctrl #(.GROUPS(4), .MS_CYC(4), .EMERG_SEC(5), .DEB_TICKS(2)) u_lpt_ctrl (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ignition_remote_line(ign), .bus_activity_pin(bus), .text_message_pin(1'b0),
        .trig_start(trig_start), .trig_stop(trig_stop), .trig_level(trig_level),
        .buf_pending(buf_pending), .power_hold(power_hold), .acq_run(acq_run),
        .file_open(file_open), .file_close(file_close), .flush_req(flush_req),
        .led_green(led_green));
    lpt_vehicle u_lpt_vehicle (.pclk(pclk), .ign_cmd(ign_cmd), .bus_cmd(bus_cmd), .ign(ign),
        .bus(bus));
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task poll(input logic [2:0] s, input int n);
        for (int i = 0; i < n; i++) begin
            apb(1'b0, ADDR_STATUS, 0);
            if (rd[2:0] === s) break;
        end
        chk("state", {29'h0, s}, {29'h0, rd[2:0]});
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (90000) @(posedge pclk);
        fail_count++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_CTRL, 0);
        chk("ctrl", 32'h1, rd);
        apb(1'b0, ADDR_FOLLOW, 0);
        chk("follow", 32'h3c, rd);
        chk("led", 0, led_green);
        apb(1'b0, 8'h20, 0);
        chk("slverr", 1, er);
        apb(1'b1, ADDR_FOLLOW, 1);
        apb(1'b1, ADDR_POSTLIM, 4);
        apb(1'b1, ADDR_WAKETO, 1);
        ign_cmd <= 1'b1;
        @(posedge pclk);
        ign_cmd <= 1'b0;
        repeat (40) @(posedge pclk);
        chk("glitch", 0, power_hold);
        apb(1'b1, ADDR_CTRL, 3);
        repeat (3) @(posedge pclk);
        chk("led", 1, led_green);
        bus_cmd <= 1'b1;
        poll(ST_ACQ, 50);
        bus_cmd <= 1'b0;
        repeat (3600) @(posedge pclk);
        apb(1'b0, ADDR_STATUS, 0);
        chk("wait", 1, rd[2:0]);
        poll(ST_STANDBY, 300);
        apb(1'b1, ADDR_CTRL, 1);
        apb(1'b1, ADDR_TRIG_MODE, 32'he4);
        buf_pending <= 4'hf;
        ign_cmd <= 1'b1;
        poll(ST_ACQ, 50);
        chk("flush idle", 2, flush_req);
        trig_start <= 4'h5;
        trig_level <= 4'h8;
        @(posedge pclk);
        trig_start <= 4'h0;
        repeat (4) @(posedge pclk);
        chk("flush", 4'hf, flush_req);
        trig_stop <= 4'h6;
        trig_level <= 4'h0;
        @(posedge pclk);
        trig_stop <= 4'h0;
        repeat (4) @(posedge pclk);
        chk("flush stop", 1, flush_req);
        apb(1'b1, ADDR_CTRL, 32'h41);
        #1 chk("close", 1, file_close);
        @(posedge pclk);
        #1 chk("open", 1, file_open);
        ign_cmd <= 1'b0;
        poll(ST_FOLLOW, 50);
        poll(ST_POST, 1500);
        ign_cmd <= 1'b1;
        poll(ST_ACQ, 1500);
        ign_cmd <= 1'b0;
        poll(ST_POST, 1500);
        poll(ST_STANDBY, 5000);
        chk("hold", 0, power_hold);
        chk("flush off", 0, flush_req);
        apb(1'b1, ADDR_CAL_FIRST, 1);
        apb(1'b1, ADDR_CTRL, 32'h15);
        poll(ST_ACQ, 2000);
        poll(ST_STANDBY, 1500);
        chk("led cal", 1, led_green);
        summarize();
    end
endmodule
